// ### include/pdmo_pkg.sv
package pdmo_pkg;

  typedef enum logic [1:0] {
    PDMO_SLEEP,
    PDMO_WAKING,
    PDMO_RUN
  } pdmo_state_t;

endpackage

// ### include/pdmo_regs.svh
`ifndef PDMO_REGS_SVH
`define PDMO_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PDMO_REF_CLK_HZ 20000000
`define PDMO_SLEEP_FREQ_HZ 1000
`define PDMO_SLEEP_ENTRY_US 1000
// longest gap between clock edges still counted as active (1 kHz period)
`define PDMO_GAP_CYCLES ((`PDMO_REF_CLK_HZ / `PDMO_SLEEP_FREQ_HZ) - 1)
// latest sleep entry, rounded down
`define PDMO_ENTRY_CYCLES ((`PDMO_REF_CLK_HZ / 1000000) * `PDMO_SLEEP_ENTRY_US)
`define PDMO_WAKE_CYCLES 32768
`define PDMO_FIFO_DEPTH 16
`define PDMO_FIFO_WIDTH 1
// reset values
`define PDMO_LFSR_SEED 16'hACE1

`endif

// ### testbench/pdmo_codec_model.sv
`timescale 1ns/1ns
module pdmo_codec_model (
  input wire logic run,
  input wire logic slot,
  input wire logic data_out,
  input wire logic data_oe,
  output logic pdm_clk,
  output logic cap_bit,
  output logic [31:0] cap_seq
);
  logic line_reg = 1'b0;
  initial begin
    pdm_clk = 1'b0;
    cap_bit = 1'b0;
    cap_seq = 32'h0000_0000;
  end
  // bit clock made here, still and low between runs
  always begin
    wait (run);
    #7;
    while (run) begin
      pdm_clk = 1'b1;
      #200;
      pdm_clk = 1'b0;
      #200;
    end
  end
  // no pull: released line reads inverse of last level
  // selected slot taken at the edge ending its half
  always @(pdm_clk) begin
    line_reg = data_oe ? data_out : ~line_reg;
    if (pdm_clk == slot) begin
      cap_bit = line_reg;
      cap_seq = cap_seq + 32'h0000_0001;
    end
  end
endmodule // pdmo_codec_model

// ### testbench/pdmo_mic_checker.sv
`timescale 1ns/1ns
module pdmo_mic_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pdm_clk,
  input wire logic chan_sel,
  input wire logic [15:0] sample,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic asleep
);
  logic pin_reg;
  logic [15:0] gap_reg;
  logic [15:0] wake_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------
  // gap and wake edge counters
  // ------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_reg <= 1'b0;
      gap_reg <= 16'h0000;
    end else begin
      pin_reg <= pdm_clk;
      // saturate so a long stop never wraps back to a small gap
      gap_reg <= (pdm_clk && !pin_reg) ? 16'h0000 :
        (gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) wake_reg <= 16'h0000;
    else if (gap_reg > 16'h4e1e) wake_reg <= 16'h0000;
    else if (pdm_clk && !pin_reg && wake_reg != 16'hffff) wake_reg <= wake_reg + 16'h0001;
  end
  a_sleep_release: assert property (asleep |-> !data_oe)
    else $error("driving while asleep");
  a_sleep_entry: assert property (gap_reg > 16'h4e28 |-> asleep)
    else $error("sleep entry late");
  a_sleep_cause: assert property ($rose(asleep) |-> gap_reg > 16'h4e10)
    else $error("sleep entry early");
  a_wake_delay: assert property ($rose(data_oe) |-> wake_reg > 16'h7fff)
    else $error("output before wake count");
  a_wake_exit: assert property (wake_reg > 16'h8010 && gap_reg < 16'h0010 |-> !asleep)
    else $error("still asleep with clock running");
  a_slot_edge: assert property ($rose(data_oe) |-> $past(pdm_clk, 3) != chan_sel)
    else $error("bit launched in wrong slot");
  a_oe_half: assert property ($rose(data_oe) |-> data_oe[*3] ##[1:2] !data_oe)
    else $error("drive window wrong length");
  a_data_hold: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("data changed while driven");
  a_oe_clocked: assert property (data_oe |-> gap_reg < 16'h0010)
    else $error("driving without clock");
endmodule // pdmo_mic_checker

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic ref_clk, pdm_clk, data_out, data_oe, asleep, cap_bit;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic chan_sel = 1'b0;
  logic measure = 1'b0;
  logic last_bit = 1'b0;
  logic [15:0] sample = 16'h8000;
  logic [15:0] seen = 16'h0000;
  logic [15:0] rnd_reg = 16'he0e8;
  logic [15:0] note_q[$];
  logic [31:0] cap_seq;
  int errors = 0;
  int checks_done = 0;
  int nbits = 0;
  pdmo_mic pdmo_mic_inst (.ref_clk(ref_clk), .reset_n(reset_n), .pdm_clk(pdm_clk),
    .chan_sel(chan_sel), .sample(sample), .data_out(data_out), .data_oe(data_oe),
    .asleep(asleep));
  pdmo_codec_model pdmo_codec_model_inst (.run(run), .slot(chan_sel), .data_out(data_out),
    .data_oe(data_oe), .pdm_clk(pdm_clk), .cap_bit(cap_bit), .cap_seq(cap_seq));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------
  // monitor: repeats and ones in 32 bits
  // ------------------------------
  always @(cap_seq) begin
    if (measure) begin
      if (nbits > 0 && cap_bit === last_bit) seen = seen + 16'h0100;
      seen = seen + {15'h0000, cap_bit};
      nbits++;
      if (nbits == 32) begin
        check(seen, note_q.pop_front());
        measure = 1'b0;
      end
    end
    last_bit = cap_bit;
  end
  task automatic measure_modes;
    logic [15:0] smp[3] = '{16'h0000, 16'hffff, 16'h8000};
    logic [15:0] want[3] = '{16'h1f00, 16'h1f20, 16'h0010};
    for (int i = 0; i < 3; i++) begin
      sample = smp[i];
      repeat (400) @(negedge ref_clk);
      note_q.push_back(want[i]);
      seen = 16'h0000;
      nbits = 0;
      measure = 1'b1;
      repeat (300) @(negedge ref_clk);
      check({15'h0000, measure}, 16'h0000);
    end
  endtask
  task automatic wake(input logic sel);
    chan_sel = sel;
    run = 1'b1;
    for (int i = 0; i < 4096; i++) begin
      repeat (64) @(negedge ref_clk);
      rnd_reg = xs(rnd_reg);
      sample = rnd_reg;
      if (i == 4000) check({14'h0000, asleep, data_oe}, 16'h0000);
    end
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (40) @(negedge ref_clk);
    check({15'h0000, asleep}, 16'h0001);
    wake(1'b0); // output checked still released near the end of start-up
    measure_modes();
    run = 1'b0;
    repeat (19000) @(negedge ref_clk);
    check({15'h0000, asleep}, 16'h0000);
    repeat (1100) @(negedge ref_clk);
    check({14'h0000, asleep, data_oe}, 16'h0002);
    wake(1'b1);
    measure_modes();
    complete_run();
  end
  initial begin
    #40000000;
    errors++;
    complete_run();
  end
endmodule // testbench
bind pdmo_mic pdmo_mic_checker pdmo_mic_checker_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .pdm_clk(pdm_clk), .chan_sel(chan_sel), .sample(sample), .data_out(data_out),
  .data_oe(data_oe), .asleep(asleep));

// ### verilog/pdmo_fifo.sv
`timescale 1ns/1ns
`include "pdmo_regs.svh"

module pdmo_fifo #(
  parameter int WIDTH = `PDMO_FIFO_WIDTH,
  parameter int DEPTH = `PDMO_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // pdmo_fifo

// ### verilog/pdmo_mic.sv
`timescale 1ns/1ns
`include "pdmo_regs.svh"

module pdmo_mic
  import pdmo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pdm_clk,
  input wire logic chan_sel,
  input wire logic [15:0] sample,
  output logic data_out,
  output logic data_oe,
  output logic asleep
);
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [14:0] GAP_CYCLES = 15'(`PDMO_GAP_CYCLES);
  localparam logic [14:0] ENTRY_CYCLES = 15'(`PDMO_ENTRY_CYCLES);
  localparam logic [15:0] WAKE_LAST = 16'(`PDMO_WAKE_CYCLES - 1);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_s3_reg;
  logic sel_s1_reg;
  logic sel_s2_reg;
  logic rise;
  logic fall;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else begin
      clk_s1_reg <= pdm_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= chan_sel;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  assign rise = clk_s2_reg && !clk_s3_reg;
  assign fall = !clk_s2_reg && clk_s3_reg;

  // ---------------------------------------------------------------
  // clock activity detector on the local reference
  // ---------------------------------------------------------------
  logic [14:0] gap_reg;
  logic slow;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= ENTRY_CYCLES;
    end else if (rise) begin
      gap_reg <= 15'h0000;
    end else if (gap_reg != ENTRY_CYCLES) begin
      gap_reg <= gap_reg + 15'h0001;
    end
  end

  // no rising edge for more than one 1 kHz period means too slow
  assign slow = (gap_reg > GAP_CYCLES);

  // ---------------------------------------------------------------
  // sleep / wake state machine
  // ---------------------------------------------------------------
  pdmo_state_t state_reg;
  logic [15:0] wake_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PDMO_SLEEP;
      wake_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        PDMO_SLEEP: begin
          wake_reg <= 16'h0000;
          if (rise && !slow) begin
            state_reg <= PDMO_WAKING;
          end
        end
        PDMO_WAKING: begin
          if (slow) begin
            state_reg <= PDMO_SLEEP;
          end else if (rise) begin
            if (wake_reg == WAKE_LAST) begin
              state_reg <= PDMO_RUN;
            end
            wake_reg <= wake_reg + 16'h0001;
          end
        end
        PDMO_RUN: begin
          if (slow) begin
            state_reg <= PDMO_SLEEP;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bit source and buffer
  // ---------------------------------------------------------------
  logic mod_bit;
  logic mod_valid;
  logic mod_ready;
  logic fifo_bit;
  logic fifo_valid;
  logic take;
  logic launch;
  logic running;

  assign running = (state_reg == PDMO_RUN);
  // left slot launches on rising edge, right on falling
  assign launch = sel_s2_reg ? fall : rise;
  assign take = running && launch && fifo_valid;

  pdmo_modulator u_mod (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sample(sample),
    .out_ready(mod_ready),
    .out_bit(mod_bit),
    .out_valid(mod_valid)
  );

  pdmo_fifo #(
    .WIDTH(`PDMO_FIFO_WIDTH),
    .DEPTH(`PDMO_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .flush(state_reg == PDMO_SLEEP),
    .in_data(mod_bit),
    .in_valid(mod_valid),
    .in_ready(mod_ready),
    .out_data(fifo_bit),
    .out_valid(fifo_valid),
    .out_ready(take)
  );

  // ---------------------------------------------------------------
  // pin driver
  // ---------------------------------------------------------------
  logic release_edge;

  assign release_edge = sel_s2_reg ? rise : fall;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else if (!running) begin
      data_oe <= 1'b0;
    end else if (take) begin
      data_out <= fifo_bit;
      data_oe <= 1'b1;
    end else if (release_edge) begin
      data_oe <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      asleep <= 1'b1;
    end else begin
      asleep <= (state_reg == PDMO_SLEEP);
    end
  end
endmodule // pdmo_mic

// ### verilog/pdmo_modulator.sv
`timescale 1ns/1ns
`include "pdmo_regs.svh"

module pdmo_modulator
  import pdmo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] sample,
  input wire logic out_ready,
  output logic out_bit,
  output logic out_valid
);
  // ---------------------------------------------------------------
  // first-order sigma-delta: bit density follows sample level
  // ---------------------------------------------------------------
  logic [16:0] acc_reg;
  logic [16:0] acc_next;

  assign acc_next = {1'b0, acc_reg[15:0]} + {1'b0, sample};
  assign out_bit = acc_next[16];
  assign out_valid = 1'b1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 17'h0_0000;
    end else if (out_ready) begin
      acc_reg <= acc_next;
    end
  end
endmodule // pdmo_modulator
